// *** design/fhsc_cfg.svh ***
// Register map, field positions, reset values and timing counts of the config bank
`ifndef FHSC_CFG_SVH
`define FHSC_CFG_SVH

// Register indices; byte address is four times the index
`define FHSC_CFG_IDX 18'h0f221
`define FHSC_SPARE_IDX 18'h0f222

// Config word reset value and mask of software-writable bits
`define FHSC_CFG_RESET 16'h40c0
`define FHSC_CFG_WMASK 16'hfff0

// Field positions
`define FHSC_RM_BIT 15
`define FHSC_BRL_HI 14
`define FHSC_BRL_LO 12
`define FHSC_BL_HI 11
`define FHSC_BL_LO 9
`define FHSC_ECC_BIT 8
`define FHSC_READY_POLARITY_BIT 7
`define FHSC_INTERRUPT_POLARITY_BIT 6
`define FHSC_OBE_BIT 5
`define FHSC_RDYCONF_BIT 4

// Burst length codes and word counts
`define FHSC_BL_4 3'h1
`define FHSC_BL_8 3'h2
`define FHSC_BL_16 3'h3
`define FHSC_BL_32 3'h4
`define FHSC_WORDS_4 11'h004
`define FHSC_WORDS_8 11'h008
`define FHSC_WORDS_16 11'h010
`define FHSC_WORDS_32 11'h020
`define FHSC_WORDS_CONT 11'h400

// Smallest usable initial latency in link clocks
`define FHSC_LAT_MIN 3'h3

// AXI responses
`define FHSC_RESP_OKAY 2'h0
`define FHSC_RESP_SLVERR 2'h2

`endif

// *** design/fhsc_pkg.sv ***
// Types shared by the config bank design
package fhsc_pkg;

    // Burst read sequencer states
    typedef enum logic [1:0] {
        BURST_IDLE,
        BURST_LATENCY,
        BURST_DATA
    } fhsc_burst_state_t;

    // One configuration word
    typedef logic [15:0] fhsc_word_t;

endpackage : fhsc_pkg

// *** design/fhsc_sync2.sv ***
// Two-flop synchroniser for one level from outside the REF_CLK domain
`timescale 1ns/1ns
module fhsc_sync2 (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Level in and synchronised level out
    input wire logic async_in,
    output logic sync_out
);

    logic meta_q;

    // First stage is read only by the second stage
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : fhsc_sync2

// *** design/fhsc_top.sv ***
// System configuration register bank with burst read sequencing and pin control
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "fhsc_cfg.svh"

// Operation
// RULE1: Bit 15 picks asynchronous reads at 0 (reset) or synchronous burst reads at 1.
// RULE2: Bits 14:12 give the initial burst latency, codes 3 to 7 cycles, reset 4, 0-2 reserved.
// RULE3: Bits 11:9 give burst length: continuous (reset), 4, 8, 16, or 32 words, 110/111 reserved.
// RULE4: The host transfers exactly the number of words the burst length field asks for.
// RULE5: A continuous burst delivers up to 1K words, as many as the host clocks out.
// RULE6: Bit 8 at 0 (reset) applies error correction and at 1 bypasses it.
// RULE7: Bit 7 at 1 (reset) drives the ready pin high for ready, at 0 low for ready.
// RULE8: Bit 6 at 1 (reset) drives the interrupt pin high for ready status, at 0 inverted.
// RULE9: Ready and interrupt pins float until bit 5 is 1; polarity acts only then.
// RULE10: Bit 5 returns to 0 on cold reset or when software writes 0 to it.
// RULE11: Bit 4 at 0 (reset) raises ready one clock before burst data, at 1 with the data.
// RULE12: Writes are always asynchronous; only the two read modes are defined.
// RULE13: Bit 0 is a read-only boot buffer protect flag that always reads 0 (locked).
// RULE14: The second configuration register is reserved and holds no function.
// RULE15: Bits 3:1 are read-only zero and writes to them are ignored.
module fhsc_top #(
    parameter int ADDR_W = 20
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic SRST,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Host burst pins, asynchronous to REF_CLK
    input wire logic BURST_CLK,
    input wire logic BURST_START,
    // Internal device status, on REF_CLK
    input wire logic DEVICE_READY,
    input wire logic INT_STATUS_READY,
    // Configuration seen by the rest of the device
    output logic READ_MODE_SYNC,
    output logic ECC_BYPASS,
    // Burst sequencing
    output logic BURST_ACTIVE,
    output logic BURST_WORD_STROBE,
    output logic [10:0] BURST_WORD_IDX,
    // Ready and interrupt pins
    output logic RDY_O,
    output logic RDY_OE,
    output logic INT_O,
    output logic INT_OE
);

    // Elaboration check; the register indices need at least 20 address bits
    if (ADDR_W < 20 || ADDR_W > 32) begin : gen_addr_w_check
        $error("fhsc_top: ADDR_W must lie between 20 and 32");
    end

    // Register state
    fhsc_pkg::fhsc_word_t cfg_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic aw_held_q;
    logic [15:0] wdata_q;
    logic [1:0] wstrb_q;
    logic w_held_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic rd_spare_q;

    // Address decode
    logic aw_hit_cfg;
    logic aw_hit_spare;
    logic ar_hit_cfg;
    logic ar_hit_spare;
    logic do_write;
    logic [15:0] lane_mask;
    fhsc_pkg::fhsc_word_t cfg_d;

    assign aw_hit_cfg = awaddr_q[ADDR_W-1:2] == (ADDR_W-2)'(`FHSC_CFG_IDX);
    assign aw_hit_spare = awaddr_q[ADDR_W-1:2] == (ADDR_W-2)'(`FHSC_SPARE_IDX);
    assign ar_hit_cfg = S_AXI_ARADDR[ADDR_W-1:2] == (ADDR_W-2)'(`FHSC_CFG_IDX);
    assign ar_hit_spare = S_AXI_ARADDR[ADDR_W-1:2] == (ADDR_W-2)'(`FHSC_SPARE_IDX);
    assign do_write = aw_held_q && w_held_q && !bvalid_q;

    // Handshake outputs: accept one address and one data, in any order
    assign S_AXI_AWREADY = !aw_held_q && !bvalid_q;
    assign S_AXI_WREADY = !w_held_q && !bvalid_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;

    // Capture write address
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            aw_held_q <= 1'b0;
            awaddr_q <= '0;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held_q <= 1'b1;
            awaddr_q <= S_AXI_AWADDR;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    // Capture write data; only the low two byte lanes carry bits
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            w_held_q <= 1'b0;
            wdata_q <= 16'h0000;
            wstrb_q <= 2'h0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held_q <= 1'b1;
            wdata_q <= S_AXI_WDATA[15:0];
            wstrb_q <= S_AXI_WSTRB[1:0];
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    // Byte-lane and writable-bit mask
    assign lane_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}} & `FHSC_CFG_WMASK; // RULE15 RULE13
    assign cfg_d = (cfg_q & ~lane_mask) | (wdata_q & lane_mask);

    // Config word; cold reset restores defaults, including buffer enable off
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            cfg_q <= `FHSC_CFG_RESET; // RULE10
        end else if (do_write && aw_hit_cfg) begin
            cfg_q <= cfg_d; // RULE10
        end
    end

    // Write response; the spare word swallows writes without error
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            bvalid_q <= 1'b0;
            bresp_q <= `FHSC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= (aw_hit_cfg || aw_hit_spare) ? `FHSC_RESP_OKAY : `FHSC_RESP_SLVERR; // RULE14
        end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read channel: answer one cycle after the address is taken
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `FHSC_RESP_OKAY;
            rd_spare_q <= 1'b0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_q <= 1'b1;
            rd_spare_q <= ar_hit_spare;
            rdata_q <= ar_hit_cfg ? {16'h0000, cfg_q} : 32'h00000000; // RULE14 RULE13
            rresp_q <= (ar_hit_cfg || ar_hit_spare) ? `FHSC_RESP_OKAY : `FHSC_RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // Field views
    logic mode_sync;
    logic [2:0] lat_code;
    logic [2:0] len_code;
    logic rdy_pol;
    logic int_pol;
    logic buf_en;
    logic rdy_conf;
    logic [2:0] latency;
    logic [10:0] words;

    // Only two modes exist: async or sync read, write always async
    assign mode_sync = cfg_q[`FHSC_RM_BIT]; // RULE1 RULE12
    assign lat_code = cfg_q[`FHSC_BRL_HI:`FHSC_BRL_LO];
    assign len_code = cfg_q[`FHSC_BL_HI:`FHSC_BL_LO];
    assign rdy_pol = cfg_q[`FHSC_READY_POLARITY_BIT];
    assign int_pol = cfg_q[`FHSC_INTERRUPT_POLARITY_BIT];
    assign buf_en = cfg_q[`FHSC_OBE_BIT];
    assign rdy_conf = cfg_q[`FHSC_RDYCONF_BIT];

    // Reserved latency codes fall back to the minimum, as no count below it works
    assign latency = (lat_code < `FHSC_LAT_MIN) ? `FHSC_LAT_MIN : lat_code; // RULE2

    // Burst length decode; reserved codes behave as continuous
    always_comb begin
        unique case (len_code)
            `FHSC_BL_4: words = `FHSC_WORDS_4; // RULE3
            `FHSC_BL_8: words = `FHSC_WORDS_8;
            `FHSC_BL_16: words = `FHSC_WORDS_16;
            `FHSC_BL_32: words = `FHSC_WORDS_32;
            default: words = `FHSC_WORDS_CONT; // RULE5
        endcase
    end

    // Synchronise host burst pins
    logic lclk_s;
    logic start_s;
    logic lclk_d_q;
    logic start_d_q;
    logic lclk_rise;
    logic start_rise;

    fhsc_sync2 u_sync_clk (
        .clk(REF_CLK),
        .srst(SRST),
        .async_in(BURST_CLK),
        .sync_out(lclk_s)
    );

    fhsc_sync2 u_sync_start (
        .clk(REF_CLK),
        .srst(SRST),
        .async_in(BURST_START),
        .sync_out(start_s)
    );

    // Edge detect on synchronised levels
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            lclk_d_q <= 1'b0;
            start_d_q <= 1'b0;
        end else begin
            lclk_d_q <= lclk_s;
            start_d_q <= start_s;
        end
    end

    assign lclk_rise = lclk_s && !lclk_d_q;
    assign start_rise = start_s && !start_d_q;

    // Burst sequencer
    fhsc_pkg::fhsc_burst_state_t state_q;
    logic [2:0] edge_cnt_q;
    logic [10:0] word_cnt_q;
    logic last_lat_edge;
    logic last_word;

    assign last_lat_edge = (edge_cnt_q + 3'h1) == latency;
    assign last_word = (word_cnt_q + 11'h001) == words;

    // A new start restarts the burst; async mode never enters it
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state_q <= fhsc_pkg::BURST_IDLE;
            edge_cnt_q <= 3'h0;
            word_cnt_q <= 11'h000;
        end else if (start_rise && mode_sync) begin
            state_q <= fhsc_pkg::BURST_LATENCY; // RULE1
            edge_cnt_q <= 3'h0;
            word_cnt_q <= 11'h000;
        end else if (do_write && aw_hit_cfg) begin
            // Config write closes an open burst, so a new length never meets an old count
            state_q <= fhsc_pkg::BURST_IDLE; // RULE12
        end else if (!mode_sync) begin
            state_q <= fhsc_pkg::BURST_IDLE; // RULE12
        end else if (lclk_rise) begin
            unique case (state_q)
                fhsc_pkg::BURST_IDLE: begin
                    state_q <= fhsc_pkg::BURST_IDLE;
                end
                fhsc_pkg::BURST_LATENCY: begin
                    edge_cnt_q <= edge_cnt_q + 3'h1; // RULE2
                    if (last_lat_edge) begin
                        state_q <= fhsc_pkg::BURST_DATA;
                    end
                end
                fhsc_pkg::BURST_DATA: begin
                    word_cnt_q <= word_cnt_q + 11'h001;
                    // Device stops at the length; host must not clock further
                    if (last_word) begin
                        state_q <= fhsc_pkg::BURST_IDLE; // RULE3 RULE4 RULE5
                    end
                end
            endcase
        end
    end

    // Ready level: in sync mode early by one link clock unless configured to match data; async mode follows DEVICE_READY
    logic in_data;
    logic rdy_level;

    assign in_data = state_q == fhsc_pkg::BURST_DATA;

    always_comb begin
        if (!mode_sync) begin
            rdy_level = DEVICE_READY;
        end else if (rdy_conf) begin
            rdy_level = in_data; // RULE11
        end else begin
            rdy_level = in_data || (state_q == fhsc_pkg::BURST_LATENCY && last_lat_edge); // RULE11
        end
    end

    // Registered pin drive; polarity only matters while buffers are on
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            RDY_O <= 1'b0;
            RDY_OE <= 1'b0;
            INT_O <= 1'b0;
            INT_OE <= 1'b0;
        end else begin
            RDY_OE <= buf_en; // RULE9
            INT_OE <= buf_en; // RULE9
            RDY_O <= buf_en && (rdy_pol ? rdy_level : !rdy_level); // RULE7
            INT_O <= buf_en && (int_pol ? INT_STATUS_READY : !INT_STATUS_READY); // RULE8
        end
    end

    // Registered configuration and burst outputs
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            READ_MODE_SYNC <= 1'b0;
            ECC_BYPASS <= 1'b0;
            BURST_ACTIVE <= 1'b0;
            BURST_WORD_STROBE <= 1'b0;
            BURST_WORD_IDX <= 11'h000;
        end else begin
            READ_MODE_SYNC <= mode_sync; // RULE1
            ECC_BYPASS <= cfg_q[`FHSC_ECC_BIT]; // RULE6
            BURST_ACTIVE <= state_q != fhsc_pkg::BURST_IDLE;
            BURST_WORD_STROBE <= in_data && lclk_rise && !(start_rise && mode_sync);
            BURST_WORD_IDX <= word_cnt_q;
        end
    end

    // Checks
    AST_RO_ZERO: assert property (@(posedge REF_CLK) disable iff (SRST) // RULE13 RULE15
        cfg_q[3:0] == 4'h0)
        else $error("read-only low bits not zero");

    AST_RESET_DEFAULT: assert property (@(posedge REF_CLK) // RULE10
        $past(SRST) |-> cfg_q == `FHSC_CFG_RESET && !buf_en)
        else $error("config word not at default after reset");

    AST_PIN_ENABLE: assert property (@(posedge REF_CLK) disable iff (SRST) // RULE9
        ##1 (RDY_OE == $past(buf_en)) && (INT_OE == $past(buf_en)))
        else $error("pin enables do not follow buffer enable");

    AST_INT_POLARITY: assert property (@(posedge REF_CLK) disable iff (SRST) // RULE8
        $past(buf_en) && !$past(SRST) |-> INT_O == ($past(int_pol) ~^ $past(INT_STATUS_READY)))
        else $error("interrupt pin polarity wrong");

    AST_RDY_POLARITY: assert property (@(posedge REF_CLK) disable iff (SRST) // RULE7
        $past(buf_en) && !$past(SRST) |-> RDY_O == ($past(rdy_pol) ~^ $past(rdy_level)))
        else $error("ready pin polarity wrong");

    AST_LATENCY_COUNT: assert property (@(posedge REF_CLK) disable iff (SRST) // RULE2
        $rose(in_data) |-> edge_cnt_q == latency && edge_cnt_q >= `FHSC_LAT_MIN)
        else $error("burst data began at wrong latency");

    AST_LENGTH_BOUND: assert property (@(posedge REF_CLK) disable iff (SRST) // RULE3 RULE5
        in_data |-> word_cnt_q < words)
        else $error("burst ran past its length");

    AST_RDY_EARLY: assert property (@(posedge REF_CLK) disable iff (SRST) // RULE11
        $rose(in_data) && !rdy_conf && $stable(cfg_q) |-> $past(rdy_level))
        else $error("ready not one clock ahead of data");

    AST_ASYNC_NO_BURST: assert property (@(posedge REF_CLK) disable iff (SRST) // RULE1 RULE12
        !mode_sync |=> !in_data)
        else $error("burst active in asynchronous mode");

    AST_SPARE_ZERO: assert property (@(posedge REF_CLK) disable iff (SRST) // RULE14
        rvalid_q && rd_spare_q |-> rdata_q == 32'h00000000 && rresp_q == `FHSC_RESP_OKAY)
        else $error("spare register read not zero");

    AST_ECC_FOLLOW: assert property (@(posedge REF_CLK) disable iff (SRST) // RULE6
        $changed(cfg_q[`FHSC_ECC_BIT]) |=> ECC_BYPASS == $past(cfg_q[`FHSC_ECC_BIT]))
        else $error("correction bypass output stale");

    // Main scenarios
    COV_CFG_WRITE: cover property (@(posedge REF_CLK) disable iff (SRST)
        do_write && aw_hit_cfg);
    COV_BURST_DONE: cover property (@(posedge REF_CLK) disable iff (SRST)
        in_data ##1 state_q == fhsc_pkg::BURST_IDLE);
    COV_PINS_ON: cover property (@(posedge REF_CLK) disable iff (SRST)
        $rose(RDY_OE));
    COV_UNMAPPED: cover property (@(posedge REF_CLK) disable iff (SRST)
        rvalid_q && rresp_q == `FHSC_RESP_SLVERR);

endmodule : fhsc_top

// *** tb/fhsc_host_link.sv ***
// Host side model: drives the burst start and link clock pins
`timescale 1ns/1ns
module fhsc_host_link (
    // Frame request from the bench
    input wire logic go,
    input wire logic [10:0] n_clk,
    // Link pins and frame status
    output logic link_clk,
    output logic link_start,
    output logic busy
);
    // Idle between frames: link clock stands still low
    initial begin
        link_clk = 1'b0;
        link_start = 1'b0;
        busy = 1'b0;
    end
    // One frame; odd offset keeps the link phase apart from REF_CLK
    always @(posedge go) begin
        busy = 1'b1;
        #7;
        link_start = 1'b1;
        #160;
        repeat (n_clk) begin
            link_clk = 1'b1;
            #80;
            link_clk = 1'b0;
            #80;
        end
        link_start = 1'b0;
        #320;
        busy = 1'b0;
    end
endmodule : fhsc_host_link

// *** tb/fhsc_top_tb.sv ***
// Self-checking bench for the system configuration register bank
`timescale 1ns/1ns
`include "fhsc_cfg.svh"
module fhsc_top_tb;
    localparam logic [19:0] CFG_A = {`FHSC_CFG_IDX, 2'b00};
    localparam logic [19:0] SPR_A = {`FHSC_SPARE_IDX, 2'b00};
    logic clk, srst, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic bvalid, arready, rvalid, b_clk, b_start, dev_rdy, int_rdy, go, busy;
    logic rm_sync, ecc_byp, b_act, b_stb, rdy_o, rdy_oe, int_o, int_oe, first_rdy, pre_rdy;
    logic [19:0] awaddr, araddr;
    logic [31:0] wdata, rdata, q, d;
    logic [1:0] bresp, rresp, r;
    logic [10:0] n_clk, b_idx;
    int errors, checked, seed, cyc, words, rises, first_rises, lat_l;

    fhsc_top dut_u (.REF_CLK(clk), .SRST(srst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .BURST_CLK(b_clk), .BURST_START(b_start), .DEVICE_READY(dev_rdy),
        .INT_STATUS_READY(int_rdy), .READ_MODE_SYNC(rm_sync), .ECC_BYPASS(ecc_byp),
        .BURST_ACTIVE(b_act), .BURST_WORD_STROBE(b_stb), .BURST_WORD_IDX(b_idx),
        .RDY_O(rdy_o), .RDY_OE(rdy_oe), .INT_O(int_o), .INT_OE(int_oe));
    fhsc_host_link host_u (.go(go), .n_clk(n_clk), .link_clk(b_clk),
        .link_start(b_start), .busy(busy));

    // Free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Hang guard: a run far past its expected length is a failure
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            errors = errors + 1;
            $display("MISMATCH at %0t: run timed out", $time);
            end_of_test();
        end
    end

    // Link edges seen by the host, and words delivered by the device
    // Ready level seen at the last latency edge, before the device has counted it
    always @(posedge b_clk) begin
        rises = rises + 1;
        if (rises == lat_l) pre_rdy = rdy_o;
    end
    always @(posedge clk) begin
        if (b_stb === 1'b1) begin
            if (words == 0) begin
                first_rises = rises;
                first_rdy = rdy_o;
            end
            chk({21'h0, b_idx}, words);
            words = words + 1;
        end
    end

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // Write one word; each channel released once taken
    task automatic axw(input logic [19:0] a, input logic [31:0] v);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axw

    // Read one word
    task automatic axr(input logic [19:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        q = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axr

    // One burst frame; host clocks latency plus exactly n words
    task automatic burst(input logic [2:0] lat, input logic [2:0] bl, input logic conf,
        input int n);
        int l;
        l = (lat < 3) ? 3 : lat;
        axw(CFG_A, {16'h0, 1'b1, lat, bl, 4'h7, conf, 4'h0});
        words = 0;
        rises = 0;
        lat_l = l;
        pre_rdy = 1'bx;
        n_clk <= 11'(l + n);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        while (busy) @(posedge clk);
        chk(words, n);
        chk(first_rises, l + 1);
        chk({31'h0, first_rdy}, 1);
        chk({31'h0, pre_rdy}, {31'h0, !conf});
        if (bl != 3'h0) chk({31'h0, b_act}, 0);
    endtask : burst

    // Summary and verdict
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // Main sequence
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, go, dev_rdy, int_rdy} = 8'h00;
        {awaddr, araddr, wdata, n_clk} = '0;
        {errors, checked, cyc, words, rises} = '0;
        seed = 32'h5c09;
        srst = 1'b1;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        axr(CFG_A);
        chk(q, {16'h0, `FHSC_CFG_RESET});
        chk({rdy_oe, int_oe, rdy_o, int_o}, 0);
        $display("reset values test done");
        // Random words, with all-ones and all-zeros corners
        for (int i = 0; i < 10; i++) begin
            d = (i == 0) ? 32'h0000ffff : (i == 1) ? 32'h0 : $random(seed);
            axw(CFG_A, d);
            chk(r, `FHSC_RESP_OKAY);
            axr(CFG_A);
            chk(q, {16'h0, d[15:4], 4'h0});
            chk({31'h0, ecc_byp}, d[8]);
            chk({31'h0, rm_sync}, d[15]);
            chk({rdy_oe, int_oe}, {2{d[5]}});
        end
        $display("register test done");
        axw(SPR_A, 32'hffffffff);
        chk(r, `FHSC_RESP_OKAY);
        axr(SPR_A);
        chk(q, 0);
        axw(20'h00100, 32'h0000ffff);
        chk(r, `FHSC_RESP_SLVERR);
        axr(20'h00100);
        chk({q, r}, {32'h0, `FHSC_RESP_SLVERR});
        $display("spare and unmapped test done");
        // Every polarity pair, asynchronous read mode
        for (int p = 0; p < 4; p++) begin
            axw(CFG_A, {24'h0, p[1], p[0], 6'h20});
            repeat (4) begin
                dev_rdy <= $random(seed);
                int_rdy <= $random(seed);
                repeat (4) @(posedge clk);
                chk({31'h0, rdy_o}, {31'h0, dev_rdy ~^ p[1]});
                chk({31'h0, int_o}, {31'h0, int_rdy ~^ p[0]});
            end
        end
        $display("pin polarity test done");
        dev_rdy <= 1'b1;
        int_rdy <= 1'b1;
        // Lengths 4..32 and continuous, latencies 3..7
        for (int i = 0; i < 5; i++) begin
            burst(3'(3 + i), 3'(i), i[0], (i == 0) ? 40 : (4 << (i - 1)));
        end
        burst(3'h2, 3'h1, 1'b0, 4);
        axw(CFG_A, 32'h000040e0);
        repeat (3) @(posedge clk);
        chk({31'h0, b_act}, 0);
        $display("burst test done");
        // Cold reset in mid-run drops the pin drivers
        srst <= 1'b1;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        axr(CFG_A);
        chk(q, {16'h0, `FHSC_CFG_RESET});
        chk({rdy_oe, int_oe}, 0);
        $display("second reset test done");
        end_of_test();
    end
endmodule : fhsc_top_tb
